// [counter_pkg.sv]
// Constants and types shared by the up/down counter design files
package counter_pkg;

  // Counter geometry
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CNT_MAX = 4'hF;
  localparam logic [CNT_W-1:0] CNT_MIN = 4'h0;

  // Synchroniser depth and bundle width of pin inputs
  localparam int SYNC_STAGES = 2;
  localparam int PIN_W = 8;

  // Bit positions of the pin bundle handed to the synchroniser
  localparam int PIN_PRESET_LSB = 0;
  localparam int PIN_DOWN = 4;
  localparam int PIN_ENABLE_N = 5;
  localparam int PIN_LOAD_N = 6;
  localparam int PIN_CLOCK = 7;

  // Register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] CTRL_OFFS = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFFS = 8'h04;

  // Control register fields and reset value
  localparam int CTRL_INHIBIT_BIT = 0;
  localparam logic CTRL_INHIBIT_RESET = 1'h0;

  // Status register fields
  localparam int STAT_COUNT_LSB = 0;
  localparam int STAT_TC_BIT = 4;
  localparam int STAT_RIPPLE_BIT = 5;
  localparam int STAT_LOAD_BIT = 6;
  localparam int STAT_DOWN_BIT = 7;

  // Unmapped reads and idle read data
  localparam logic [DATA_W-1:0] RDATA_IDLE = 8'h00;

  // Ripple-clock output sequencer
  typedef enum logic {
    RIP_IDLE,
    RIP_LOW
  } ripple_state_t;

endpackage

// [sync_stage.sv]
// Two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module sync_stage #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  // First stage, read only by the second stage
  logic [W-1:0] meta_q;
  // Second stage, safe for logic to read
  logic [W-1:0] stable_q;

  // One pair of flops per bit
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      // Capture and settle the pin level
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          meta_q[gi] <= 1'b0;
          stable_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= async_i[gi];
          stable_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  // Settled levels out
  assign sync_o = stable_q;

endmodule

// [updown_counter.sv]
// Reversible 4-bit counter with preset, terminal count and ripple clock
`timescale 1ns/1ps
module updown_counter
  import counter_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic COUNT_CLOCK_I,
  input wire logic ASYNC_LOAD_N_I,
  input wire logic COUNT_ENABLE_N_I,
  input wire logic COUNT_DOWN_I,
  input wire logic [CNT_W-1:0] PRESET_INPUTS_I,
  output logic [CNT_W-1:0] COUNT_OUTPUTS_O,
  output logic TERMINAL_COUNT_O,
  output logic RIPPLE_CLOCK_N_O,
  input wire logic [ADDR_W-1:0] REG_ADDR_I,
  input wire logic [DATA_W-1:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [DATA_W-1:0] REG_RDATA_O
);

  // Terminal-count decode, feeding the terminal count output, ripple and status paths
  function automatic logic tc_decode(
    input logic [CNT_W-1:0] cnt,
    input logic down
  );
    logic hit;
    hit = 1'b0;
    // Top of range counting up, bottom counting down
    if (down) begin
      hit = (cnt == CNT_MIN);
    end else begin
      hit = (cnt == CNT_MAX);
    end
    return hit;
  endfunction

  // ------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------

  // Raw pin levels gathered into one bundle
  logic [PIN_W-1:0] pins_w;
  // Pin levels after two flops
  logic [PIN_W-1:0] pins_s;

  assign pins_w = {COUNT_CLOCK_I,
                   ASYNC_LOAD_N_I,
                   COUNT_ENABLE_N_I,
                   COUNT_DOWN_I,
                   PRESET_INPUTS_I};

  // All pins cross into the system clock here
  sync_stage #(
    .W(PIN_W)
  ) u_pin_sync (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RST_N_I),
    .async_i(pins_w),
    .sync_o(pins_s)
  );

  // Settled pin levels, named
  logic clk_s;
  logic load_n_s;
  logic enable_n_s;
  logic down_s;
  logic [CNT_W-1:0] preset_s;

  assign clk_s = pins_s[PIN_CLOCK];
  assign load_n_s = pins_s[PIN_LOAD_N];
  assign enable_n_s = pins_s[PIN_ENABLE_N];
  assign down_s = pins_s[PIN_DOWN];
  assign preset_s = pins_s[PIN_PRESET_LSB +: CNT_W];

  // ------------------------------------------------------------
  // Count clock edge detection
  // ------------------------------------------------------------

  // Previous settled count clock level
  logic clk_prev_q;

  // Remember last settled clock level
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      clk_prev_q <= 1'b0;
    end else begin
      clk_prev_q <= clk_s;
    end
  end

  // Edges of the count clock, one system cycle each
  logic clk_rise_w;
  logic clk_fall_w;

  assign clk_rise_w = clk_s & ~clk_prev_q;
  assign clk_fall_w = ~clk_s & clk_prev_q;

  // ------------------------------------------------------------
  // Software control
  // ------------------------------------------------------------

  // Software count inhibit, acts like enable held high
  logic inhibit_q;
  // Register write decode
  logic ctrl_wr_w;

  assign ctrl_wr_w = REG_WR_I & (REG_ADDR_I == CTRL_OFFS);

  // Control register
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      inhibit_q <= CTRL_INHIBIT_RESET;
    end else if (ctrl_wr_w) begin
      inhibit_q <= REG_WDATA_I[CTRL_INHIBIT_BIT];
    end
  end

  // Effective active-low enable: pin or software inhibit
  logic enable_n_w;

  assign enable_n_w = enable_n_s | inhibit_q;

  // ------------------------------------------------------------
  // Count datapath
  // ------------------------------------------------------------

  // Present count and its next value
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  // Count stepped one place in the selected direction
  logic [CNT_W-1:0] stepped_w;
  // Preset is overriding the counter
  logic load_active_w;
  // An enabled rising edge of the count clock
  logic count_step_w;

  // Width-matched add or subtract wraps on its own
  assign stepped_w = down_s ? (count_q - CNT_ONE)
                            : (count_q + CNT_ONE);

  // Load low wins over every counting input
  assign load_active_w = ~load_n_s;

  // Only rising clock edges with enable low step the count
  assign count_step_w = clk_rise_w & ~enable_n_w;

  // Next count: preset, step, or hold
  assign count_d = load_active_w ? preset_s
                 : count_step_w ? stepped_w
                 : count_q;

  // Count register
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      count_q <= CNT_RESET;
    end else begin
      count_q <= count_d;
    end
  end

  // ------------------------------------------------------------
  // Terminal count
  // ------------------------------------------------------------

  // Terminal count, aligned with the count register
  logic tc_q;
  // Decoded from next count and present direction
  logic tc_d;

  // Decode needs only count and direction, never enable
  assign tc_d = tc_decode(count_d, down_s);

  // Terminal count register
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      tc_q <= 1'b0;
    end else begin
      tc_q <= tc_d;
    end
  end

  // ------------------------------------------------------------
  // Ripple clock
  // ------------------------------------------------------------

  // Ripple sequencer state
  ripple_state_t rip_q;
  ripple_state_t rip_d;
  // Ripple output, active low
  logic ripple_n_q;
  logic ripple_n_d;
  // Conditions that arm the low pulse
  logic rip_arm_w;

  // Enable low and terminal count high arm it
  assign rip_arm_w = ~enable_n_w & tc_q;

  // Next state of the ripple output
  always_comb begin
    rip_d = rip_q;
    ripple_n_d = 1'b1;
    case (rip_q)
      RIP_IDLE: begin
        // Falling clock edge while armed starts the pulse
        if (clk_fall_w && rip_arm_w) begin
          rip_d = RIP_LOW;
          ripple_n_d = 1'b0;
        end
      end
      RIP_LOW: begin
        // Rising clock edge ends it at once
        if (clk_rise_w) begin
          rip_d = RIP_IDLE;
          ripple_n_d = 1'b1;
        // Enable going high kills the pulse
        end else if (enable_n_w) begin
          rip_d = RIP_IDLE;
          ripple_n_d = 1'b1;
        end else begin
          ripple_n_d = 1'b0;
        end
      end
      default: begin
        // Recover to idle
        rip_d = RIP_IDLE;
        ripple_n_d = 1'b1;
      end
    endcase
  end

  // Ripple state and output registers
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rip_q <= RIP_IDLE;
      ripple_n_q <= 1'b1;
    end else begin
      rip_q <= rip_d;
      ripple_n_q <= ripple_n_d;
    end
  end

  // ------------------------------------------------------------
  // Register read port
  // ------------------------------------------------------------

  // Status word built from live state
  logic [DATA_W-1:0] status_w;
  // Control word read back
  logic [DATA_W-1:0] ctrl_w;
  // Selected read word
  logic [DATA_W-1:0] rd_sel_w;
  // Read data register
  logic [DATA_W-1:0] rdata_q;

  // Pack status fields
  always_comb begin
    status_w = RDATA_IDLE;
    status_w[STAT_COUNT_LSB +: CNT_W] = count_q;
    status_w[STAT_TC_BIT] = tc_q;
    status_w[STAT_RIPPLE_BIT] = ripple_n_q;
    status_w[STAT_LOAD_BIT] = load_active_w;
    status_w[STAT_DOWN_BIT] = down_s;
  end

  // Pack control fields
  always_comb begin
    ctrl_w = RDATA_IDLE;
    ctrl_w[CTRL_INHIBIT_BIT] = inhibit_q;
  end

  // Address decode, unmapped reads return zero
  assign rd_sel_w = (REG_ADDR_I == CTRL_OFFS) ? ctrl_w
                  : (REG_ADDR_I == STATUS_OFFS) ? status_w
                  : RDATA_IDLE;

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rdata_q <= RDATA_IDLE;
    end else if (REG_RD_I) begin
      rdata_q <= rd_sel_w;
    end else begin
      rdata_q <= RDATA_IDLE;
    end
  end

  // ------------------------------------------------------------
  // Outputs, each straight from a flop
  // ------------------------------------------------------------

  assign COUNT_OUTPUTS_O = count_q;
  assign TERMINAL_COUNT_O = tc_q;
  assign RIPPLE_CLOCK_N_O = ripple_n_q;
  assign REG_RDATA_O = rdata_q;

endmodule

// [counter_monitor.sv]
// Port checker for the up/down counter, bound to its top module
`timescale 1ns/1ps
module counter_monitor
  import counter_pkg::*;
(
  input logic SYS_CLK_I,
  input logic RST_N_I,
  input logic COUNT_CLOCK_I,
  input logic ASYNC_LOAD_N_I,
  input logic COUNT_ENABLE_N_I,
  input logic COUNT_DOWN_I,
  input logic [CNT_W-1:0] PRESET_INPUTS_I,
  input logic [CNT_W-1:0] COUNT_OUTPUTS_O,
  input logic TERMINAL_COUNT_O,
  input logic RIPPLE_CLOCK_N_O,
  input logic [ADDR_W-1:0] REG_ADDR_I,
  input logic [DATA_W-1:0] REG_WDATA_I,
  input logic REG_WR_I,
  input logic REG_RD_I,
  input logic [DATA_W-1:0] REG_RDATA_O
);
  logic inh_q; // Mirror of the inhibit bit
  // Follow writes to the control register
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      inh_q <= 1'b0;
    end else if (REG_WR_I && REG_ADDR_I == CTRL_OFFS) begin
      inh_q <= REG_WDATA_I[CTRL_INHIBIT_BIT];
    end
  end
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  a_count_step: assert property (
    (ASYNC_LOAD_N_I && $stable(COUNT_DOWN_I))[*4] ##1
    $changed(COUNT_OUTPUTS_O) |-> COUNT_OUTPUTS_O ==
    4'($past(COUNT_OUTPUTS_O) + ($past(COUNT_DOWN_I) ? 4'hF : 4'h1)))
    else $error("count step wrong");
  a_rise_only: assert property (
    ASYNC_LOAD_N_I[*4] ##1 $changed(COUNT_OUTPUTS_O) |->
    $past(COUNT_CLOCK_I, 3) && !$past(COUNT_CLOCK_I, 4))
    else $error("count moved without clock rise");
  a_load_copy: assert property (
    (!ASYNC_LOAD_N_I && $stable(PRESET_INPUTS_I))[*4] |->
    COUNT_OUTPUTS_O == PRESET_INPUTS_I)
    else $error("preset not copied");
  a_count_hold: assert property (
    (COUNT_ENABLE_N_I && ASYNC_LOAD_N_I)[*4] |=> $stable(COUNT_OUTPUTS_O))
    else $error("count moved while disabled");
  a_tc_decode: assert property (
    $stable(COUNT_DOWN_I)[*4] |-> TERMINAL_COUNT_O == (COUNT_DOWN_I ?
    COUNT_OUTPUTS_O == CNT_MIN : COUNT_OUTPUTS_O == CNT_MAX))
    else $error("terminal count wrong");
  a_rip_fall: assert property (
    COUNT_CLOCK_I ##1 (!COUNT_CLOCK_I && !COUNT_ENABLE_N_I &&
    TERMINAL_COUNT_O && !inh_q)[*4] |-> !RIPPLE_CLOCK_N_O)
    else $error("ripple pulse missing");
  a_rip_inhibit: assert property (
    COUNT_ENABLE_N_I[*4] |-> RIPPLE_CLOCK_N_O)
    else $error("ripple pulse while disabled");
  a_rip_release: assert property (
    COUNT_CLOCK_I[*4] |-> RIPPLE_CLOCK_N_O)
    else $error("ripple low in clock high phase");
  a_rdata_idle: assert property (
    !REG_RD_I |=> REG_RDATA_O == RDATA_IDLE)
    else $error("read data not idle");
  c_ripple: cover property (!RIPPLE_CLOCK_N_O);
  c_tc_rise: cover property ($rose(TERMINAL_COUNT_O));
  c_status: cover property (REG_RD_I && REG_ADDR_I == STATUS_OFFS);
endmodule
bind updown_counter counter_monitor mon (.SYS_CLK_I, .RST_N_I,
  .COUNT_CLOCK_I, .ASYNC_LOAD_N_I, .COUNT_ENABLE_N_I, .COUNT_DOWN_I,
  .PRESET_INPUTS_I, .COUNT_OUTPUTS_O, .TERMINAL_COUNT_O,
  .RIPPLE_CLOCK_N_O, .REG_ADDR_I, .REG_WDATA_I, .REG_WR_I, .REG_RD_I,
  .REG_RDATA_O);

// [pulse_driver.sv]
// Controlling-logic model: bursts of count clock pulses
`timescale 1ns/1ps
module pulse_driver (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic [3:0] pulses_i,
  output logic count_clock_o,
  output logic busy_o
);
  logic [3:0] left_q; // Pulses still to send
  logic [1:0] tick_q; // Cycles spent in this phase
  assign busy_o = (left_q != 4'h0);
  // Four-cycle phases, pin rests low between bursts
  // Clock comes from its own phase counter, never from terminal count
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      left_q <= 4'h0;
      tick_q <= 2'h0;
      count_clock_o <= 1'b0;
    end else if (start_i) begin
      left_q <= pulses_i;
      tick_q <= 2'h0;
    end else if (busy_o) begin
      tick_q <= tick_q + 2'h1;
      if (tick_q == 2'h3) begin
        count_clock_o <= !count_clock_o;
        if (count_clock_o) begin
          left_q <= left_q - 4'h1;
        end
      end
    end
  end
endmodule

// [testbench.sv]
// Self-checking bench for the up/down counter
`timescale 1ns/1ps
module testbench;
  import counter_pkg::*;
  logic sys_clk, rst_n, load_n, en_n, dn, wr, rd, start, tc, rc, cclk, busy;
  logic [3:0] preset, npulse, cnt;
  logic [7:0] addr, wdata, rdata;
  int n_mismatch, check_count, cyc;
  logic look_en_n; // Lookahead enable a following stage would get
  // Global enable gated into the carry with this stage's terminal count
  assign look_en_n = en_n | ~tc;
  updown_counter dut (.SYS_CLK_I(sys_clk), .RST_N_I(rst_n),
    .COUNT_CLOCK_I(cclk), .ASYNC_LOAD_N_I(load_n), .COUNT_ENABLE_N_I(en_n),
    .COUNT_DOWN_I(dn), .PRESET_INPUTS_I(preset), .COUNT_OUTPUTS_O(cnt),
    .TERMINAL_COUNT_O(tc), .RIPPLE_CLOCK_N_O(rc), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata));
  pulse_driver ctl (.clk_i(sys_clk), .rst_n_i(rst_n), .start_i(start),
    .pulses_i(npulse), .count_clock_o(cclk), .busy_o(busy));
  // 200 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Cut a hang short
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Compare ripple, terminal count and count together
  task automatic see(input logic [3:0] c, input logic t, input logic r);
    #1;
    chk({2'h0, rc, tc, cnt}, {2'h0, r, t, c});
  endtask
  // Ask the partner for a burst, then let the syncs settle
  task automatic go(input logic [3:0] n);
    @(posedge sys_clk);
    start <= 1'b1;
    npulse <= n;
    @(posedge sys_clk);
    start <= 1'b0;
    @(posedge sys_clk);
    for (int i = 0; i < 100 && busy; i++) @(posedge sys_clk);
    repeat (5) @(posedge sys_clk);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  // Preset set first, load pulsed afterwards
  task automatic preload(input logic [3:0] v);
    @(posedge sys_clk);
    preset <= v;
    repeat (4) @(posedge sys_clk);
    load_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    load_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
  endtask
  task automatic s_load();
    preload(4'h5);
    see(4'h5, 1'b0, 1'b1);
    @(posedge sys_clk);
    preset <= 4'h9;
    repeat (4) @(posedge sys_clk);
    load_n <= 1'b0;
    go(4'h2);
    see(4'h9, 1'b0, 1'b1);
    rreg(STATUS_OFFS, 8'h69);
    @(posedge sys_clk);
    load_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    see(4'h9, 1'b0, 1'b1);
    go(4'h1);
    see(4'hA, 1'b0, 1'b1);
  endtask
  task automatic s_up();
    preload(4'hE);
    go(4'h1);
    see(4'hF, 1'b1, 1'b0);
    chk({7'h0, look_en_n}, 8'h00);
    go(4'h1);
    see(4'h0, 1'b0, 1'b1);
  endtask
  task automatic s_down();
    @(posedge sys_clk);
    dn <= 1'b1;
    go(4'h1);
    see(4'hF, 1'b0, 1'b1);
    preload(4'h1);
    go(4'h1);
    see(4'h0, 1'b1, 1'b0);
  endtask
  task automatic s_hold();
    @(posedge sys_clk);
    en_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    see(4'h0, 1'b1, 1'b1);
    rreg(STATUS_OFFS, 8'hB0);
    chk({7'h0, look_en_n}, 8'h01);
    go(4'h3);
    see(4'h0, 1'b1, 1'b1);
    @(posedge sys_clk);
    dn <= 1'b0;
    repeat (5) @(posedge sys_clk);
    see(4'h0, 1'b0, 1'b1);
    @(posedge sys_clk);
    en_n <= 1'b0;
  endtask
  task automatic s_regs();
    wreg(CTRL_OFFS, 8'h01);
    go(4'h1);
    see(4'h0, 1'b0, 1'b1);
    rreg(STATUS_OFFS, 8'h20);
    rreg(8'h08, 8'h00);
    wreg(STATUS_OFFS, 8'hFF);
    rreg(CTRL_OFFS, 8'h01);
    wreg(CTRL_OFFS, 8'h00);
    go(4'h1);
    see(4'h1, 1'b0, 1'b1);
  endtask
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Reset, then run every scenario
  initial begin
    {rst_n, load_n, en_n, dn, wr, rd, start} = 7'b0100000;
    {preset, npulse, addr, wdata} = 24'h0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    see(4'h0, 1'b0, 1'b1);
    s_load();
    s_up();
    s_down();
    s_hold();
    s_regs();
    wrap_up();
  end
endmodule
